//--- rtl/rbs_pkg.sv
// Purpose: shared constants and types of the receiver support block
// Assumes: 10 MHz clock, APB with 32-bit data
// Notes: register offsets are byte addresses
package rbs_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_RATE = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_CORR = 8'h08;
  localparam logic [7:0] OFS_FEI = 8'h0c;
  localparam logic [7:0] OFS_CBW = 8'h10;
  localparam logic [7:0] OFS_RXBW = 8'h14;
  localparam logic [7:0] OFS_OFFS = 8'h18;
  localparam logic [7:0] OFS_FREQ = 8'h1c;
  localparam logic [7:0] OFS_TEMP = 8'h20;
  localparam logic [7:0] OFS_TOUT = 8'h24;
  // Field positions in the correction control register
  localparam int B_START = 0;
  localparam int B_FEI = 1;
  localparam int B_AUTO = 2;
  localparam int B_ACLR = 3;
  localparam int B_DONE = 4;
  localparam int B_LOWIX = 5;
  // Reset values
  localparam logic [15:0] RST_RATE = 16'h682b;
  localparam logic [7:0] RST_BW = 8'h55;
  localparam logic [23:0] RST_FREQ = 24'he4c000;
  // Operating mode codes from the sequencer
  localparam logic [2:0] MODE_STBY = 3'h1;
  localparam logic [2:0] MODE_FS = 3'h2;
  localparam logic [2:0] MODE_RX = 3'h4;
  // Timing: bits per timeout count, bits per frequency-error evaluation
  localparam logic [2:0] TOUT_BITS_SHIFT = 3'h3; // times 8 bit periods
  localparam logic [1:0] FEI_LAST_BIT = 2'h3; // four bit periods
  // Temperature conversion limit: 100 us, rounded down to cycles
  localparam int CLK_PERIOD_NS = 100;
  localparam int TEMP_LIMIT_NS = 100000;
  localparam logic [9:0] TEMP_CYCLES = 10'(TEMP_LIMIT_NS / CLK_PERIOD_NS - 1);
  // Low-index offset unit against the synthesizer step
  localparam int OFFSET_UNIT_HZ = 488;
  localparam int FREQ_STEP_HZ = 61;
  localparam int OFFSET_SHIFT = 3; // 488 / 61 = 8 steps per count
  // APB request bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rbs_apb_s;
  // Correction sequencer states
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_CLEAR = 4'h2,
    S_MEAS = 4'h4,
    S_APPLY = 4'h8
  } rbs_afc_e;
endpackage : rbs_pkg

//--- rtl/rbs_bitsync.sv
// Purpose: bit synchronizer, recovers a data clock from the bit stream
// Assumes: dataIn comes from the demodulator on the same clock
// Notes: divisor below 3 gives no useful clock
`timescale 1ns/1ps
`default_nettype none
module rbs_bitsync (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, high
  input wire logic [15:0] divisor, // Clocks per bit
  input wire logic enable, // Synchronizer on
  input wire logic dataIn, // Raw demodulated bit
  output logic dclk, // Recovered clock
  output logic dataOut, // Clean data
  output logic bitTick // One pulse per nominal bit
);
  logic [15:0] phase; // Position within the bit
  logic prevData; // Last raw bit
  wire edgeSeen = dataIn ^ prevData; // Level transition
  wire atWrap = (phase >= divisor - 16'h0001); // End of bit
  wire atMid = (phase == {1'b0, divisor[15:1]}); // Sample point

  // Phase counter: free runs at the nominal rate, so a long run of
  // equal bits keeps alignment; an edge only pulls the phase back
  always_ff @(posedge clk) begin
    if (rst) begin
      phase <= 16'h0000;
      prevData <= 1'b0;
      bitTick <= 1'b0;
    end else begin
      prevData <= dataIn;
      bitTick <= atWrap;
      if (enable && edgeSeen) begin
        phase <= 16'h0001;
      end else if (atWrap) begin
        phase <= 16'h0000;
      end else begin
        phase <= phase + 16'h0001;
      end
    end
  end

  // Output stage: data sampled mid-bit, clock rises with the sample
  always_ff @(posedge clk) begin
    if (rst) begin
      dclk <= 1'b0;
      dataOut <= 1'b0;
    end else if (!enable) begin
      dclk <= 1'b0;
      dataOut <= dataIn;
    end else if (atMid) begin
      dclk <= 1'b1;
      dataOut <= dataIn;
    end else if (atWrap) begin
      dclk <= 1'b0;
    end
  end

  chk_run_lock: assert property (@(posedge clk) disable iff (rst)
    enable && !edgeSeen && atWrap |=> phase == 16'h0000)
    else $error("phase lost alignment during a run");
endmodule : rbs_bitsync
`default_nettype wire

//--- rtl/rbs_aux_top.sv
// Purpose: bit sync, frequency error, correction, temperature, timeout
// Assumes: demodulator, sequencer and ADC signals share the clock
// Notes: APB slave answers with one wait-free access phase
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rbs_aux_top (
  input wire logic clk, // 10 MHz clock
  input wire logic rst, // Synchronous reset, high
  input wire rbs_pkg::rbs_apb_s apbIn, // APB request
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [2:0] opMode, // Sequencer mode
  input wire logic packetMode, // Packet mode selected
  input wire logic demodData, // Demodulated bit
  input wire logic signed [15:0] freqErrSample, // Offset in steps
  input wire logic signalThreshFlag, // Signal level threshold
  input wire logic [7:0] tempAdcCode, // Sensor code, rises with heat
  input wire logic tempAdcValid, // Sensor conversion done
  output logic recoveredClockPin, // Recovered data clock
  output logic syncData, // Synchronized data
  output logic [7:0] channelBwSel, // Channel filter bandwidth
  output logic [2:0] dcCancelCutoffSel, // DC canceller cutoff
  output logic [23:0] carrierFreq, // Carrier frequency word
  output logic tempAdcEnable, // Converter on sensor
  output logic rxBlocksOff, // Receive blocks powered down
  output logic timeoutIrq, // Timeout pulse
  output logic receiverReadyIrq // Receiver ready pulse
);
  // Register contents
  logic [15:0] rateDivisor; // High and low divisor bytes
  logic syncOff; // Synchronizer off in continuous mode
  logic correctionStart; // Correction request
  logic feiStart; // Measure-only request
  logic autoCorrectionEnable; // Correct on each rx entry
  logic autoCorrectionClear; // Drop old correction first
  logic lowIndexEnable; // Add offset to correction, not to the stored result
  logic feiDone; // Last evaluation finished
  logic signed [15:0] freqErrorResult; // Last measured offset
  logic signed [15:0] freqCorrectionValue; // Correction in force
  logic [7:0] corrBw; // Bandwidth during correction
  logic [2:0] dcCancelCutoff; // Cutoff during correction
  logic [7:0] rxBw; // Normal bandwidth
  logic signed [7:0] lowIndexOffset; // Offset in 488 Hz counts
  logic tempRunning; // Temperature conversion active
  logic [7:0] tempResult; // Temperature reading
  logic [9:0] tempCnt; // Conversion time
  logic [7:0] startTimeoutCount; // Timeout before threshold
  logic [7:0] postThreshTimeoutCount; // Timeout after threshold

  // APB decode
  wire apbSetup = apbIn.psel & ~apbIn.penable; // Setup cycle
  wire apbAccess = apbIn.psel & apbIn.penable & pready; // Completing
  wire wrEn = apbAccess & apbIn.pwrite; // Write strobe
  wire [7:0] addr = apbIn.paddr; // Byte address
  wire [31:0] wd = apbIn.pwdata; // Write data
  wire selRate = (addr == rbs_pkg::OFS_RATE);
  wire selCtrl = (addr == rbs_pkg::OFS_CTRL);
  wire selCorr = (addr == rbs_pkg::OFS_CORR);
  wire selFei = (addr == rbs_pkg::OFS_FEI);
  wire selCbw = (addr == rbs_pkg::OFS_CBW);
  wire selRxbw = (addr == rbs_pkg::OFS_RXBW);
  wire selOffs = (addr == rbs_pkg::OFS_OFFS);
  wire selFreq = (addr == rbs_pkg::OFS_FREQ);
  wire selTemp = (addr == rbs_pkg::OFS_TEMP);
  wire selTout = (addr == rbs_pkg::OFS_TOUT);
  wire mapped = selRate | selCtrl | selCorr | selFei | selCbw | selRxbw
    | selOffs | selFreq | selTemp | selTout;
  wire [7:0] corrBits = {2'h0, lowIndexEnable, feiDone, autoCorrectionClear,
    autoCorrectionEnable, feiStart, correctionStart};
  wire [31:0] rdMux =
    selRate ? {16'h0000, rateDivisor} :
    selCtrl ? {31'h00000000, syncOff} :
    selCorr ? {24'h000000, corrBits} :
    selFei ? {freqCorrectionValue, freqErrorResult} :
    selCbw ? {21'h000000, dcCancelCutoff, corrBw} :
    selRxbw ? {24'h000000, rxBw} :
    selOffs ? {24'h000000, lowIndexOffset} :
    selFreq ? {8'h00, carrierFreq} :
    selTemp ? {16'h0000, tempResult, 6'h00, tempRunning, 1'b0} :
    selTout ? {16'h0000, postThreshTimeoutCount, startTimeoutCount} :
    32'h00000000;

  // Bus answer: data and error prepared in setup, ready in access
  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= apbSetup;
      prdata <= apbSetup ? rdMux : 32'h00000000;
      pslverr <= apbSetup & ~mapped;
    end
  end

  // Plain configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      rateDivisor <= rbs_pkg::RST_RATE;
      syncOff <= 1'b0;
      corrBw <= rbs_pkg::RST_BW;
      dcCancelCutoff <= 3'h4;
      rxBw <= rbs_pkg::RST_BW;
      lowIndexOffset <= 8'h00;
      startTimeoutCount <= 8'h00;
      postThreshTimeoutCount <= 8'h00;
    end else if (wrEn) begin
      if (selRate) rateDivisor <= wd[15:0];
      if (selCtrl) syncOff <= wd[0];
      if (selCbw) corrBw <= wd[7:0];
      if (selCbw) dcCancelCutoff <= wd[10:8];
      if (selRxbw) rxBw <= wd[7:0];
      if (selOffs) lowIndexOffset <= wd[7:0];
      if (selTout) startTimeoutCount <= wd[7:0];
      if (selTout) postThreshTimeoutCount <= wd[15:8];
    end
  end

  // Bit synchronizer; packet mode overrides the off setting
  wire syncOn = packetMode | ~syncOff;
  logic bsClk; // Recovered clock
  logic bsData; // Clean data
  logic bitTick; // Nominal bit period mark
  rbs_bitsync u_bitsync (
    .clk(clk),
    .rst(rst),
    .divisor(rateDivisor),
    .enable(syncOn),
    .dataIn(demodData),
    .dclk(bsClk),
    .dataOut(bsData),
    .bitTick(bitTick)
  );

  // Pin stage for the recovered clock and data
  always_ff @(posedge clk) begin
    if (rst) begin
      recoveredClockPin <= 1'b0;
      syncData <= 1'b0;
    end else begin
      recoveredClockPin <= bsClk;
      syncData <= bsData;
    end
  end

  // Receive entry detection
  logic rxPrev; // Mode was receive
  wire rxMode = (opMode == rbs_pkg::MODE_RX);
  wire rxRise = rxMode & ~rxPrev;

  // Correction sequencer
  rbs_pkg::rbs_afc_e afcState;
  rbs_pkg::rbs_afc_e next_afcState;
  logic doCorrect; // Current run corrects, not just measures
  logic [1:0] measBits; // Bit periods measured
  logic signed [17:0] errSum; // Sum of four samples
  wire autoTrig = rxRise & autoCorrectionEnable;
  wire manTrig = correctionStart & ~autoCorrectionEnable;
  wire anyTrig = autoTrig | manTrig | feiStart;
  wire measEnd = bitTick & (measBits == rbs_pkg::FEI_LAST_BIT);
  wire signed [15:0] feiNow = errSum[17:2]; // Mean in steps
  wire signed [15:0] offsSteps =
    16'(lowIndexOffset) <<< rbs_pkg::OFFSET_SHIFT;
  wire signed [15:0] corrNow = lowIndexEnable ? feiNow + offsSteps : feiNow;
  wire [23:0] corrExt = {{8{corrNow[15]}}, corrNow};
  wire [23:0] prevExt = {{8{freqCorrectionValue[15]}}, freqCorrectionValue};

  // Next state of the correction sequencer
  always_comb begin
    next_afcState = afcState;
    unique case (afcState)
      rbs_pkg::S_IDLE: begin
        if (autoTrig && autoCorrectionClear) begin
          next_afcState = rbs_pkg::S_CLEAR;
        end else if (anyTrig) begin
          next_afcState = rbs_pkg::S_MEAS;
        end
      end
      rbs_pkg::S_CLEAR: next_afcState = rbs_pkg::S_MEAS;
      rbs_pkg::S_MEAS: if (measEnd) next_afcState = rbs_pkg::S_APPLY;
      rbs_pkg::S_APPLY: next_afcState = rbs_pkg::S_IDLE;
      default: next_afcState = rbs_pkg::S_IDLE;
    endcase
  end

  // Measurement accumulation over four bit periods
  always_ff @(posedge clk) begin
    if (rst) begin
      afcState <= rbs_pkg::S_IDLE;
      measBits <= 2'h0;
      errSum <= 18'sh0;
      doCorrect <= 1'b0;
      rxPrev <= 1'b0;
    end else begin
      afcState <= next_afcState;
      rxPrev <= rxMode;
      if (afcState == rbs_pkg::S_IDLE) begin
        measBits <= 2'h0;
        errSum <= 18'sh0;
        doCorrect <= autoTrig | manTrig;
      end else if (afcState == rbs_pkg::S_MEAS && bitTick) begin
        measBits <= measBits + 2'h1;
        errSum <= errSum + 18'(freqErrSample);
      end
    end
  end

  // Correction control bits, result and carrier word
  always_ff @(posedge clk) begin
    if (rst) begin
      correctionStart <= 1'b0;
      feiStart <= 1'b0;
      autoCorrectionEnable <= 1'b0;
      autoCorrectionClear <= 1'b0;
      lowIndexEnable <= 1'b0;
      feiDone <= 1'b0;
      freqErrorResult <= 16'sh0;
      freqCorrectionValue <= 16'sh0;
      carrierFreq <= rbs_pkg::RST_FREQ;
    end else begin
      if (anyTrig && afcState == rbs_pkg::S_IDLE) feiDone <= 1'b0;
      if (afcState == rbs_pkg::S_CLEAR) begin
        carrierFreq <= carrierFreq + prevExt;
        freqCorrectionValue <= 16'sh0;
      end
      if (afcState == rbs_pkg::S_APPLY) begin
        freqErrorResult <= feiNow;
        feiDone <= 1'b1;
        feiStart <= 1'b0;
        correctionStart <= 1'b0;
        if (doCorrect) begin
          carrierFreq <= carrierFreq - corrExt;
          freqCorrectionValue <= freqCorrectionValue + corrNow;
        end
      end
      // Software write comes last so a request written in the S_APPLY cycle is not lost
      if (wrEn && selCorr) begin
        correctionStart <= correctionStart | wd[rbs_pkg::B_START];
        feiStart <= feiStart | wd[rbs_pkg::B_FEI];
        autoCorrectionEnable <= wd[rbs_pkg::B_AUTO];
        autoCorrectionClear <= wd[rbs_pkg::B_ACLR];
        lowIndexEnable <= wd[rbs_pkg::B_LOWIX];
      end
      if (wrEn && selFreq) carrierFreq <= wd[23:0];
    end
  end

  // Filter selection: wider bandwidth while correcting
  always_ff @(posedge clk) begin
    if (rst) begin
      channelBwSel <= rbs_pkg::RST_BW;
      dcCancelCutoffSel <= 3'h4;
    end else if (afcState != rbs_pkg::S_IDLE && doCorrect) begin
      channelBwSel <= corrBw;
      dcCancelCutoffSel <= dcCancelCutoff;
    end else begin
      channelBwSel <= rxBw;
      dcCancelCutoffSel <= 3'h4;
    end
  end

  // Temperature conversion; the time limit guards a missing done
  wire modeOk = (opMode == rbs_pkg::MODE_STBY) | (opMode == rbs_pkg::MODE_FS);
  wire tempReq = wrEn & selTemp & wd[0];
  wire tempEnd = tempAdcValid | (tempCnt == rbs_pkg::TEMP_CYCLES);
  always_ff @(posedge clk) begin
    if (rst) begin
      tempRunning <= 1'b0;
      tempCnt <= 10'h000;
      tempResult <= 8'h00;
    end else if (tempRunning) begin
      tempCnt <= tempCnt + 10'h001;
      if (tempEnd) begin
        tempRunning <= 1'b0;
        tempResult <= ~tempAdcCode;
      end
    end else if (tempReq && modeOk) begin
      tempRunning <= 1'b1;
      tempCnt <= 10'h000;
    end
  end
  assign tempAdcEnable = tempRunning;
  assign rxBlocksOff = tempRunning;

  // Receive timeout and ready events
  logic threshSeen; // Threshold flag has risen
  logic threshPrev; // Flag last cycle
  logic toFired; // One timeout per reception unless the threshold rises in the start timeout cycle
  logic readyPending; // Ready waits for auto correction
  logic [10:0] toBits; // Bit periods in this phase
  wire [10:0] startLimit = {startTimeoutCount, 3'h0};
  wire [10:0] postLimit = {postThreshTimeoutCount, 3'h0};
  wire [10:0] toLimit = threshSeen ? postLimit : startLimit;
  wire toHit = rxMode & ~toFired & (toLimit != 11'h000) & (toBits == toLimit);
  always_ff @(posedge clk) begin
    if (rst) begin
      threshSeen <= 1'b0;
      threshPrev <= 1'b0;
      toFired <= 1'b0;
      toBits <= 11'h000;
      timeoutIrq <= 1'b0;
    end else begin
      threshPrev <= signalThreshFlag;
      timeoutIrq <= toHit;
      if (!rxMode) begin
        threshSeen <= 1'b0;
        toFired <= 1'b0;
        toBits <= 11'h000;
      end else if (signalThreshFlag && !threshPrev && !threshSeen) begin
        threshSeen <= 1'b1;
        toBits <= 11'h000;
      end else if (toHit) begin
        toFired <= 1'b1;
      end else if (bitTick && !toFired) begin
        toBits <= toBits + 11'h001;
      end
    end
  end

  // Ready pulse at rx entry, or after the automatic correction
  always_ff @(posedge clk) begin
    if (rst) begin
      readyPending <= 1'b0;
      receiverReadyIrq <= 1'b0;
    end else begin
      receiverReadyIrq <= 1'b0;
      if (rxRise && !autoCorrectionEnable) begin
        receiverReadyIrq <= 1'b1;
      end else if (rxRise) begin
        readyPending <= 1'b1;
      end else if (readyPending && afcState == rbs_pkg::S_APPLY) begin
        readyPending <= 1'b0;
        receiverReadyIrq <= 1'b1;
      end
    end
  end

  chk_sync_off: assert property (@(posedge clk) disable iff (rst)
    !syncOn [*3] |-> !recoveredClockPin)
    else $error("recovered clock runs while synchronizer is off");
  chk_packet_sync: assert property (@(posedge clk) disable iff (rst)
    packetMode [*3] |-> !$past(u_bitsync.enable, 1) == 1'b0)
    else $error("packet mode left synchronizer off");
  chk_fei_four: assert property (@(posedge clk) disable iff (rst)
    afcState == rbs_pkg::S_APPLY |-> $past(measBits) == rbs_pkg::FEI_LAST_BIT)
    else $error("evaluation did not span four bit periods");
  chk_fei_store: assert property (@(posedge clk) disable iff (rst)
    afcState == rbs_pkg::S_APPLY |=> freqErrorResult == $past(feiNow) && feiDone)
    else $error("result not stored");
  chk_carrier_sub: assert property (@(posedge clk) disable iff (rst)
    afcState == rbs_pkg::S_APPLY && doCorrect && !(wrEn && selFreq)
      |=> carrierFreq == $past(carrierFreq) - $past(corrExt))
    else $error("correction not subtracted from carrier");
  chk_start_clear: assert property (@(posedge clk) disable iff (rst)
    afcState == rbs_pkg::S_APPLY && !(wrEn && selCorr) |=> !correctionStart)
    else $error("start bit did not self-clear");
  chk_corr_bw: assert property (@(posedge clk) disable iff (rst)
    afcState == rbs_pkg::S_MEAS && doCorrect |=> channelBwSel == corrBw)
    else $error("correction bandwidth not selected");
  chk_temp_mode: assert property (@(posedge clk) disable iff (rst)
    $rose(tempRunning) |-> $past(modeOk))
    else $error("temperature started outside standby or synthesizer");
  chk_temp_time: assert property (@(posedge clk) disable iff (rst)
    tempRunning |-> tempCnt <= rbs_pkg::TEMP_CYCLES)
    else $error("temperature conversion overran");
  chk_timeout_cause: assert property (@(posedge clk) disable iff (rst)
    timeoutIrq |-> $past(rxMode) && $past(toBits) == $past(toLimit))
    else $error("timeout without elapsed count");
endmodule : rbs_aux_top
`default_nettype wire

//--- tb/rbs_tx_model.sv
// Purpose: far-side transmitter model that drives the demodulated bit stream
// Assumes: one bit lasts bitLen clocks, the receiver's programmed rate
// Notes: payload is random, never more than 15 equal bits in a row
`timescale 1ns/1ps
`default_nettype none
module rbs_tx_model (
  input wire logic clk, // System clock
  input wire logic run, // Transmit enable
  input wire logic preamble, // Send alternating bits
  input wire logic [15:0] bitLen, // Clocks per bit
  output logic txBit // Bit on the air
);
  logic [15:0] tick = '0; // Clocks into current bit
  logic [4:0] same = '0; // Equal bits in a row
  logic [31:0] lfsr = 32'h1d35; // Payload source
  initial txBit = 1'b0;
  // Exact rate match, so long equal runs must not lose lock
  always @(posedge clk) begin
    lfsr <= {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    if (!run) begin
      // Idle line carries noise, not a held level
      tick <= '0;
      txBit <= lfsr[3];
    end else if (tick == bitLen - 16'h0001) begin
      tick <= '0;
      // A run of 15 forces a flip, so any 16 bits hold a transition
      if (preamble || same == 5'h0e) begin
        txBit <= ~txBit;
        same <= '0;
      end else begin
        same <= (lfsr[0] == txBit) ? same + 5'h01 : 5'h00;
        txBit <= lfsr[0];
      end
    end else begin
      tick <= tick + 16'h0001;
    end
  end
endmodule : rbs_tx_model
`default_nettype wire

//--- tb/tb_rx_bitsync_afc_aux.sv
// Purpose: self-checking bench of the receiver support block
// Assumes: APB slave answers in the access cycle; divisor set to 16
// Notes: random values from an xorshift seeded with 32'he871
`timescale 1ns/1ps
`default_nettype none
module tb_rx_bitsync_afc_aux;
  logic clk = 1'b0; // Bench clock
  logic rst = 1'b1; // Reset, high
  rbs_pkg::rbs_apb_s apbIn = '0; // APB request
  logic [31:0] prdata; // Read data
  logic pready, pslverr, err; // APB answer
  logic [2:0] opMode = rbs_pkg::MODE_STBY; // Mode
  logic packetMode = 1'b0, tempAdcValid = 1'b0, signalThreshFlag = 1'b0; // Controls
  logic demodData, recoveredClockPin, syncData, tempAdcEnable, rxBlocksOff; // Pins
  logic timeoutIrq, receiverReadyIrq; // Pulses
  logic signed [15:0] freqErrSample = '0; // Offset seen
  logic [7:0] tempAdcCode = '0, channelBwSel, off; // Codes
  logic [2:0] dcCancelCutoffSel; // Cutoff
  logic [23:0] carrierFreq, expF, tot = '0; // Carrier, expected, corrections in force
  logic txRun = 1'b0, txPre = 1'b1; // Partner controls
  logic [31:0] rng = 32'he871, rd; // Random state, read word
  int failures = 0, samples_checked = 0, cycles = 0, readyCnt = 0, n, e;
  always #50 clk = ~clk;
  rbs_aux_top dut_u (.clk(clk), .rst(rst), .apbIn(apbIn), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .opMode(opMode), .packetMode(packetMode), .demodData(demodData),
    .freqErrSample(freqErrSample), .signalThreshFlag(signalThreshFlag),
    .tempAdcCode(tempAdcCode), .tempAdcValid(tempAdcValid),
    .recoveredClockPin(recoveredClockPin), .syncData(syncData), .channelBwSel(channelBwSel),
    .dcCancelCutoffSel(dcCancelCutoffSel), .carrierFreq(carrierFreq),
    .tempAdcEnable(tempAdcEnable), .rxBlocksOff(rxBlocksOff), .timeoutIrq(timeoutIrq),
    .receiverReadyIrq(receiverReadyIrq));
  rbs_tx_model txm (.clk(clk), .run(txRun), .preamble(txPre), .bitLen(16'h0010),
    .txBit(demodData));
  // Cycle ceiling cuts a hang short; ready pulses counted
  always @(posedge clk) begin
    cycles++;
    if (receiverReadyIrq === 1'b1) readyCnt++;
    if (cycles > 60000) begin
      failures++;
      give_verdict();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    apbIn <= {1'b1, 1'b0, w, a, d}; // Setup: psel high, penable low
    @(posedge clk);
    apbIn.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    apbIn <= '0;
    @(posedge clk);
  endtask : apb
  // Read until a status bit drops, bounded
  task automatic poll(input logic [7:0] a, input int b);
    int k;
    k = 0;
    do begin
      apb(1'b0, a, '0);
      k++;
    end while (rd[b] !== 1'b0 && k < 200);
  endtask : poll
  // Rising edges of the recovered clock over a span
  task automatic edges(input int c, output int r);
    logic p;
    r = 0;
    p = recoveredClockPin;
    repeat (c) begin
      @(posedge clk);
      if (recoveredClockPin === 1'b1 && p === 1'b0) begin
        r++;
        // Mid-bit sample still matches the bit on the line
        chk({31'h0, syncData}, {31'h0, demodData});
      end
      p = recoveredClockPin;
    end
  endtask : edges
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, rbs_pkg::OFS_RATE, '0);
    chk(rd, 32'h682b);
    apb(1'b0, rbs_pkg::OFS_FREQ, '0);
    chk(rd, 32'he4c000);
    apb(1'b1, 8'h40, 32'h1);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, rbs_pkg::OFS_RATE, 32'h10);
    apb(1'b1, rbs_pkg::OFS_TOUT, 32'h2);
    // Temperature in standby: running, then inverted code
    rng = xs(rng);
    tempAdcCode <= rng[7:0];
    apb(1'b1, rbs_pkg::OFS_TEMP, 32'h1);
    chk({31'h0, rd[1] | tempAdcEnable}, 32'h1);
    chk({30'h0, rxBlocksOff, tempAdcEnable}, 32'h3);
    apb(1'b0, rbs_pkg::OFS_TEMP, '0);
    chk({31'h0, rd[1]}, 32'h1);
    tempAdcValid <= 1'b1;
    @(posedge clk);
    tempAdcValid <= 1'b0;
    poll(rbs_pkg::OFS_TEMP, 1);
    chk({24'h0, rd[15:8]}, {24'h0, ~tempAdcCode});
    // Receive entry: one ready pulse, timeout after 2 x 8 bits
    txRun <= 1'b1;
    opMode <= rbs_pkg::MODE_RX;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (timeoutIrq !== 1'b1 && n < 1000);
    chk(32'(n >= 240 && n <= 272), 32'h1);
    chk(32'(readyCnt), 32'h1);
    // Manual correction, plain then low index, during preamble
    apb(1'b1, rbs_pkg::OFS_CBW, 32'h3a7);
    for (int i = 0; i < 2; i++) begin
      rng = xs(rng);
      apb(1'b1, rbs_pkg::OFS_FREQ, {8'h0, rng[31:8]});
      off = {3'h1, rng[4:0]};
      freqErrSample <= 16'(signed'(rng[14:8]));
      expF = rng[31:8] - 24'(signed'(rng[14:8])) - (i == 1 ? 24'(signed'(off)) * 8 : '0);
      tot = tot + rng[31:8] - expF;
      apb(1'b1, rbs_pkg::OFS_OFFS, {24'h0, off});
      apb(1'b1, rbs_pkg::OFS_CORR, (i == 1) ? 32'h21 : 32'h1);
      repeat (2) @(posedge clk);
      chk({21'h0, dcCancelCutoffSel, channelBwSel}, 32'h3a7);
      poll(rbs_pkg::OFS_CORR, rbs_pkg::B_START);
      chk({31'h0, rd[rbs_pkg::B_DONE]}, 32'h1);
      apb(1'b0, rbs_pkg::OFS_FEI, '0);
      chk({16'h0, rd[15:0]}, {16'h0, 16'(signed'(rng[14:8]))});
      chk({8'h0, carrierFreq}, {8'h0, expF});
    end
    chk({21'h0, dcCancelCutoffSel, channelBwSel}, {21'h0, 3'h4, rbs_pkg::RST_BW});
    // Recovered clock: forced by packet mode, off when disabled
    txPre <= 1'b0;
    apb(1'b1, rbs_pkg::OFS_CTRL, 32'h1);
    packetMode <= 1'b1;
    edges(320, e);
    chk(32'(e >= 18 && e <= 21), 32'h1);
    packetMode <= 1'b0;
    edges(32, e);
    edges(320, e);
    chk(32'(e), 32'h0);
    apb(1'b1, rbs_pkg::OFS_CTRL, 32'h0);
    edges(320, e);
    chk(32'(e >= 18 && e <= 21), 32'h1);
    // Auto correction with clear on rx re-entry, then post-threshold timeout
    txPre <= 1'b1;
    opMode <= rbs_pkg::MODE_FS;
    apb(1'b1, rbs_pkg::OFS_TOUT, 32'h100);
    apb(1'b1, rbs_pkg::OFS_CORR, 32'hc);
    rng = xs(rng);
    freqErrSample <= 16'(signed'(rng[14:8]));
    expF = expF + tot - 24'(signed'(rng[14:8]));
    opMode <= rbs_pkg::MODE_RX;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (readyCnt < 2 && n < 1000);
    chk(32'(readyCnt), 32'h2);
    chk({8'h0, carrierFreq}, {8'h0, expF});
    apb(1'b0, rbs_pkg::OFS_FEI, '0);
    chk(rd, {2{16'(signed'(rng[14:8]))}});
    signalThreshFlag <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (timeoutIrq !== 1'b1 && n < 1000);
    chk(32'(n >= 112 && n <= 144), 32'h1);
    // Temperature start refused in receive mode
    apb(1'b1, rbs_pkg::OFS_TEMP, 32'h1);
    chk({30'h0, rxBlocksOff, tempAdcEnable}, 32'h0);
    give_verdict();
  end
endmodule : tb_rx_bitsync_afc_aux
`default_nettype wire
